// ---- rtl/pvt_pkg.sv ----
// Package: constants for the parallel video source controller
package pvt_pkg;
  // Pixel format and frame geometry
  localparam int PIX_W          = 24;
  localparam int CNT_W          = 16;
  localparam int CLK_MHZ        = 100;
  localparam logic [CNT_W-1:0] H_ACTIVE = 16'h0010;
  localparam logic [CNT_W-1:0] V_ACTIVE = 16'h0004;
  localparam logic [CNT_W-1:0] ARRAY_LINES = 16'h0004;
  // Line timing in link clock periods
  localparam logic [CNT_W-1:0] HSYNC_W   = 16'h0004;
  localparam logic [CNT_W-1:0] HSYNC_MAX = 16'h0080;
  localparam logic [CNT_W-1:0] H_BP      = 16'h0004;
  localparam logic [CNT_W-1:0] H_FP      = 16'h0008;
  // Frame timing in lines
  localparam logic [CNT_W-1:0] VSYNC_W = 16'h0001;
  localparam logic [CNT_W-1:0] V_BP    = 16'h0006;
  localparam logic [CNT_W-1:0] V_FP    = 16'h0008;
  localparam int TVB_BASE = 6;
  localparam int TVB_MULT = 8;
  // Reset pulse and eye select guard times
  localparam real RST_LOW_US = 1.25;
  localparam int  RST_CYC = int'((RST_LOW_US * CLK_MHZ) + 0.999);
  localparam real EYE_GUARD_MS = 1.0;
  localparam int  EYE_CYC_DEF = int'((EYE_GUARD_MS * 1000.0 * CLK_MHZ) + 0.999);
  localparam int  LCLK_DIV = 8;
  localparam logic [7:0] DIV_HALF = 8'h04;
  localparam logic [7:0] RST_CNT = 8'(RST_CYC);
endpackage : pvt_pkg

// ---- rtl/pvt_buf_if.sv ----
// Interface: pixel stream handshake between buffer and top
`timescale 1ns/1ps
`default_nettype none
interface pvt_buf_if;
  import pvt_pkg::*;
  logic [PIX_W-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : pvt_buf_if
`default_nettype wire

// ---- rtl/pvt_buf.sv ----
// Two-entry pixel skid buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pvt_buf
  import pvt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  pvt_buf_if.snk    in_s,
  pvt_buf_if.src    out_s
);
  import pvt_pkg::*;
  logic [PIX_W-1:0] mem [2];
  logic             wp;
  logic             rp;
  logic [1:0]       cnt;
  logic [1:0]       next_cnt;
  logic             rdy;
  logic             push;
  logic             pop;

  // Handshake terms; ready comes from a flop so the top output is registered
  assign in_s.ready  = rdy;
  assign out_s.valid = (cnt != 2'h0);
  assign out_s.data  = mem[rp];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;
  assign next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_s.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
      rdy <= 1'b1;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= next_cnt;
      rdy <= (next_cnt != 2'h2); // Full next cycle drops ready now
    end
  end
endmodule : pvt_buf
`default_nettype wire

// ---- rtl/pvt_src.sv ----
// Video source controller driving the display controller's parallel port
`timescale 1ns/1ps
`default_nettype none
module pvt_src
  import pvt_pkg::*;
#(
  parameter int EYE_CYC = EYE_CYC_DEF
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             eye_req,
  input  wire logic [PIX_W-1:0] pix_in,
  input  wire logic             pix_in_valid,
  output logic                  pix_in_ready,
  output logic                  chip_reset_low,
  output logic                  pix_clk,
  output logic                  frame_sync,
  output logic                  line_sync,
  output logic                  pixel_valid,
  output logic [PIX_W-1:0]      pixel_bus,
  output logic                  stereo_eye_select,
  output logic                  busy
);
  import pvt_pkg::*;
  typedef enum {ST_RST, ST_IDLE, ST_RUN} pvt_state_t;
  typedef enum {PH_SYNC, PH_BP, PH_ACT, PH_FP} pvt_phase_t;

  pvt_state_t       state;
  pvt_phase_t       hph;
  logic [7:0]       rcnt;
  logic [7:0]       div;
  logic             fall;
  logic [CNT_W-1:0] hcnt;
  logic [CNT_W-1:0] line;
  logic             line_end;
  logic [CNT_W-1:0] vtot;
  logic             in_active;
  logic             eye_pend;
  logic [31:0]      eye_room;
  logic             eye_ok;
  logic             eye_s1;
  logic             eye_s2;
  logic [31:0]      vs_guard;
  pvt_buf_if        b_in ();
  pvt_buf_if        b_out ();

  // =================================================================
  // Pixel buffer
  assign b_in.data     = pix_in;
  assign b_in.valid    = pix_in_valid;
  assign pix_in_ready  = b_in.ready;
  // Drain one word per pixel clock of an active line
  assign b_out.ready   = fall && (hph == PH_ACT) && in_active && (state == ST_RUN);
  pvt_buf u_buf (
    .clk   (clk),
    .rst   (rst),
    .in_s  (b_in),
    .out_s (b_out)
  );

  // =================================================================
  // Reset pulse and run state
  always_ff @(posedge clk) begin
    if (rst) begin
      state          <= ST_RST;
      rcnt           <= 8'h00;
      chip_reset_low <= 1'b0;
      busy           <= 1'b0;
    end else begin
      case (state)
        ST_RST: begin
          rcnt <= rcnt + 8'h01;
          if (rcnt >= RST_CNT) begin
            chip_reset_low <= 1'b1;
            state          <= ST_IDLE;
          end
        end
        ST_IDLE: if (start) begin
          state <= ST_RUN;
          busy  <= 1'b1;
        end
        ST_RUN: ;
        default: state <= ST_RST;
      endcase
    end
  end

  // =================================================================
  // Link clock divider; outputs move on falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      div     <= 8'h00;
      pix_clk <= 1'b0;
    end else begin
      div <= (div == 8'(LCLK_DIV - 1)) ? 8'h00 : div + 8'h01;
      if (div == 8'h00) pix_clk <= 1'b1;
      if (div == DIV_HALF) pix_clk <= 1'b0;
    end
  end
  assign fall = (div == DIV_HALF);

  // Total lines: active plus blanking of at least 6 + 8*max(1,ratio)
  assign vtot = V_ACTIVE + V_BP + V_FP;
  assign in_active = (line >= V_BP) && (line < V_BP + V_ACTIVE);
  // Last front porch pixel clock closes the line
  assign line_end  = fall && (hph == PH_FP) && (hcnt == H_FP - 16'h0001);

  // =================================================================
  // Horizontal phase sequencer
  always_ff @(posedge clk) begin
    if (rst || state != ST_RUN) begin
      hph  <= PH_SYNC;
      hcnt <= 16'h0000;
    end else if (fall) begin
      hcnt <= hcnt + 16'h0001;
      case (hph)
        PH_SYNC: if (hcnt == HSYNC_W - 16'h0001) begin
          hph  <= PH_BP;
          hcnt <= 16'h0000;
        end
        PH_BP: if (hcnt == H_BP - 16'h0001) begin
          hph  <= PH_ACT;
          hcnt <= 16'h0000;
        end
        PH_ACT: if (hcnt == H_ACTIVE - 16'h0001) begin
          hph  <= PH_FP;
          hcnt <= 16'h0000;
        end
        PH_FP: if (hcnt == H_FP - 16'h0001) begin
          hph  <= PH_SYNC;
          hcnt <= 16'h0000;
        end
        default: hph <= PH_SYNC;
      endcase
    end
  end

  // Line counter advanced per line sync
  always_ff @(posedge clk) begin
    if (rst || state != ST_RUN) begin
      line <= 16'h0000;
    end else if (line_end) begin
      line <= (line == vtot - 16'h0001) ? 16'h0000 : line + 16'h0001;
    end
  end

  // =================================================================
  // Pin drivers, updated at link clock falling edge
  always_ff @(posedge clk) begin
    if (rst || state != ST_RUN) begin
      frame_sync  <= 1'b0;
      line_sync   <= 1'b0;
      pixel_valid <= 1'b0;
      pixel_bus   <= '0;
    end else if (fall) begin
      frame_sync  <= (line < VSYNC_W);
      line_sync   <= (hph == PH_SYNC);
      pixel_valid <= b_out.ready && b_out.valid;
      pixel_bus   <= (b_out.ready && b_out.valid) ? b_out.data : '0;
    end
  end

  // =================================================================
  // Eye select: sync request, change only with guard to frame sync
  always_ff @(posedge clk) begin
    if (rst) begin
      eye_s1 <= 1'b0;
      eye_s2 <= 1'b0;
    end else begin
      eye_s1 <= eye_req;
      eye_s2 <= eye_s1;
    end
  end

  // Time since last frame sync change
  always_ff @(posedge clk) begin
    if (rst) begin
      vs_guard <= 32'h0;
    end else if (fall && (frame_sync != (line < VSYNC_W)) && state == ST_RUN) begin
      vs_guard <= 32'h0;
    end else if (vs_guard != 32'hffffffff) begin
      vs_guard <= vs_guard + 32'h1;
    end
  end

  // Clock cycles in the whole lines left before the next frame sync change
  assign eye_room = 32'(vtot - line - 16'h0001) * 32'(HSYNC_W + H_BP + H_ACTIVE + H_FP) * 32'(LCLK_DIV);
  // Eye may move only clear of both guard windows
  assign eye_ok   = (vs_guard >= 32'(EYE_CYC)) && (line > VSYNC_W)
                    && (eye_room >= 32'(EYE_CYC));

  // Eye update; a pending change waits for a safe window
  always_ff @(posedge clk) begin
    if (rst) begin
      stereo_eye_select <= 1'b0;
      eye_pend          <= 1'b0;
    end else begin
      if (eye_s2 != stereo_eye_select && !eye_pend) begin
        eye_pend <= 1'b1;
      end
      if (eye_pend && eye_ok) begin
        stereo_eye_select <= eye_s2;
        eye_pend          <= 1'b0;
      end
    end
  end
endmodule : pvt_src
`default_nettype wire

// ---- tb/pvt_src_monitor.sv ----
// Checker: frame and line timing assertions on the source pins
`timescale 1ns/1ps
`default_nettype none
module pvt_src_monitor
  import pvt_pkg::*;
#(
  parameter int EYE_CYC = EYE_CYC_DEF
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_reset_low,
  input wire logic frame_sync,
  input wire logic line_sync,
  input wire logic pixel_valid,
  input wire logic stereo_eye_select
);
  // ==========================================
  // Helper counters
  localparam int LN = int'(HSYNC_W + H_BP + H_ACTIVE + H_FP) * LCLK_DIV;
  localparam int TVB = TVB_BASE + TVB_MULT
                       * ((V_ACTIVE > ARRAY_LINES) ? int'((V_ACTIVE + ARRAY_LINES - 16'h0001) / ARRAY_LINES) : 1);
  int lo_c, fs_c, ls_c, hb_c, hf_c, bl_n, vb_n, ev_c, fc_c;
  // Pulse widths, spacings and line counts since each edge
  always_ff @(posedge clk) begin
    lo_c <= chip_reset_low ? 0 : lo_c + 1;
    fs_c <= frame_sync ? fs_c + 1 : 0;
    ls_c <= line_sync ? ls_c + 1 : 0;
    if (rst) begin
      {hb_c, hf_c, bl_n, vb_n, ev_c, fc_c} <= {6{32'd100000}};
    end else begin
      hb_c <= $fell(line_sync) ? 1 : hb_c + 1;
      hf_c <= $fell(pixel_valid) ? 1 : hf_c + 1;
      bl_n <= $fell(pixel_valid) ? 0 : bl_n + int'($rose(line_sync));
      vb_n <= $rose(frame_sync) ? 0 : vb_n + int'($rose(line_sync));
      ev_c <= $changed(stereo_eye_select) ? 1 : ev_c + 1;
      fc_c <= $changed(frame_sync) ? 1 : fc_c + 1;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_act_rise; $rose(pixel_valid); endsequence
  sequence s_ls_rise; $rose(line_sync); endsequence
  a_reset_low_width: assert property ($rose(chip_reset_low) |-> lo_c >= 125)
    else $error("chip reset low pulse too short");
  a_fsync_width: assert property ($fell(frame_sync) |-> fs_c >= LN)
    else $error("frame sync pulse too short");
  a_vert_back_porch: assert property (s_act_rise ##0 bl_n > 1 |-> vb_n >= 2)
    else $error("vertical back porch too short");
  a_vert_front_porch: assert property ($rose(frame_sync) |-> bl_n >= 1)
    else $error("vertical front porch too short");
  a_blank_total: assert property (s_act_rise |-> bl_n <= 1 || bl_n >= TVB + 1)
    else $error("total vertical blanking too short");
  a_hsync_width: assert property ($fell(line_sync) |-> ls_c >= 32 && ls_c <= 1024)
    else $error("line sync width out of range");
  a_hback_porch: assert property (s_act_rise |-> hb_c >= 4 * LCLK_DIV)
    else $error("horizontal back porch too short");
  a_hfront_porch: assert property (s_ls_rise |-> hf_c >= 8 * LCLK_DIV)
    else $error("horizontal front porch too short");
  a_eye_setup: assert property ($changed(frame_sync) |-> ev_c >= EYE_CYC)
    else $error("eye select changed too close before frame sync");
  a_eye_hold: assert property ($changed(stereo_eye_select) |-> fc_c >= EYE_CYC)
    else $error("eye select changed too soon after frame sync");
endmodule : pvt_src_monitor
bind pvt_src pvt_src_monitor #(.EYE_CYC(EYE_CYC)) i_mon (.clk(clk), .rst(rst), .chip_reset_low(chip_reset_low),
  .frame_sync(frame_sync), .line_sync(line_sync), .pixel_valid(pixel_valid), .stereo_eye_select(stereo_eye_select));
`default_nettype wire

// ---- tb/pvt_dev_model.sv ----
// Partner: display controller input port sampling on pix_clk rise
`timescale 1ns/1ps
`default_nettype none
module pvt_dev_model
  import pvt_pkg::*;
(
  input wire logic             chip_reset_low,
  input wire logic             pix_clk,
  input wire logic             frame_sync,
  input wire logic             line_sync,
  input wire logic             pixel_valid,
  input wire logic [PIX_W-1:0] pixel_bus
);
  // ==========================================
  // Capture
  logic [PIX_W-1:0] rx_q[$];
  int               lines, last_lines, act, last_act, pix, last_pix, frames;
  logic             ls_q, fs_q;
  // Pixels kept only while valid, lines counted by sync rises
  always @(posedge pix_clk or negedge chip_reset_low) begin
    if (!chip_reset_low) begin
      rx_q.delete();
      frames = 0;
    end else begin
      if (frame_sync && !fs_q) begin
        frames++;
        last_lines = lines;
        last_act = act;
        lines = 0;
        act = 0;
      end
      if (line_sync && !ls_q) begin
        lines++;
        act += int'(pix > 0);
        last_pix = (pix > 0) ? pix : last_pix;
        pix = 0;
      end
      if (pixel_valid) begin
        rx_q.push_back(pixel_bus);
        pix++;
      end
    end
    ls_q = line_sync;
    fs_q = frame_sync;
  end
endmodule : pvt_dev_model
`default_nettype wire

// ---- tb/tb_pvt_src.sv ----
// Testbench: video source controller against a display port model
`timescale 1ns/1ps
`default_nettype none
module tb_pvt_src;
  import pvt_pkg::*;
  // ==========================================
  // Signals and instances
  logic             clk, rst, start, eye_req, pix_in_valid, pix_in_ready, chip_reset_low, pix_clk;
  logic             frame_sync, line_sync, pixel_valid, stereo_eye_select, busy;
  logic [PIX_W-1:0] pix_in, pixel_bus;
  logic [PIX_W-1:0] exp_q[$];
  logic [31:0]      seed = 32'h7a9343ea;
  int               error_cnt, checks, n;
  pvt_src #(.EYE_CYC(200)) i_dut (.clk(clk), .rst(rst), .start(start), .eye_req(eye_req), .pix_in(pix_in),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .chip_reset_low(chip_reset_low), .pix_clk(pix_clk),
    .frame_sync(frame_sync), .line_sync(line_sync), .pixel_valid(pixel_valid), .pixel_bus(pixel_bus),
    .stereo_eye_select(stereo_eye_select), .busy(busy));
  pvt_dev_model i_dev (.chip_reset_low(chip_reset_low), .pix_clk(pix_clk), .frame_sync(frame_sync),
    .line_sync(line_sync), .pixel_valid(pixel_valid), .pixel_bus(pixel_bus));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wait_frames(input int k);
    n = 0;
    while (i_dev.frames < k && n < 30000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30000) begin
      check("frame wait", 1, 0);
      final_report();
    end
  endtask : wait_frames
  // Clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Random pixel feed held until taken, reference queue, in-order compare
  always @(posedge clk) begin
    while (i_dev.rx_q.size() > 0) check("pixel", i_dev.rx_q.pop_front(), exp_q.size() ? exp_q.pop_front() : 'x);
    if (rst) exp_q.delete();
    else if (pix_in_valid && pix_in_ready) exp_q.push_back(pix_in);
    if (rst || !pix_in_valid || pix_in_ready) begin
      seed = xs(seed);
      pix_in_valid <= !rst && seed[1:0] != 2'h0;
      pix_in <= seed[31:8];
    end
  end
  // Two runs, the second after a reset in mid-frame
  initial begin
    {rst, start, eye_req} = 3'b100;
    repeat (5) @(posedge clk);
    for (int r = 0; r < 2; r++) begin
      rst <= 0;
      @(posedge clk);
      #1;
      // Divider starts the link clock high on the first edge out of reset
      check("reset outputs", {chip_reset_low, pixel_valid, line_sync, pix_clk}, 4'h1);
      n = 0;
      while (!chip_reset_low && n < 400) begin
        @(posedge clk);
        n++;
      end
      check("reset width ok", n >= 124 && n < 400, 1);
      start <= 1;
      wait_frames(2);
      eye_req <= (r == 0);
      wait_frames(4);
      check("eye select", stereo_eye_select, r == 0);
      check("lines per frame", i_dev.last_lines, V_ACTIVE + V_BP + V_FP);
      check("active lines", i_dev.last_act, V_ACTIVE);
      check("pixels per line", i_dev.last_pix, H_ACTIVE);
      check("busy", busy, 1);
      repeat (700) @(posedge clk);
      rst <= 1;
      repeat (5) @(posedge clk);
    end
    final_report();
  end
endmodule : tb_pvt_src
`default_nettype wire
